// [core/sbs_pkg.sv]
// Shared constants and types for the subtract, swap and skip execution unit
package sbs_pkg;

    localparam int unsigned DATA_W   = 8;
    localparam int unsigned NIBBLE_W = 4;
    localparam int unsigned BIT_W    = 3;

    localparam logic [DATA_W-1:0] WR_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic              FLAG_RST  = 1'b0;

    // Instruction codes presented on the request port
    localparam logic [2:0] OP_SKIP_NONNULL_BIT   = 3'h0;
    localparam logic [2:0] OP_SKIP_NONNULL       = 3'h1;
    localparam logic [2:0] OP_SUB_MEM            = 3'h2;
    localparam logic [2:0] OP_MINUS_INTO_MEMORY  = 3'h3;
    localparam logic [2:0] OP_SUB_LITERAL        = 3'h4;
    localparam logic [2:0] OP_NIBBLE_EXCHANGE    = 3'h5;
    localparam logic [2:0] OP_NIBBLE_EXCH_TO_WR  = 3'h6;

    typedef enum logic [0:0] {
        SBS_ST_EXEC,
        SBS_ST_DUMMY
    } sbs_state_t;

    typedef struct packed {
        sbs_state_t        state;
        logic [DATA_W-1:0] working_register;
        logic              arith_range_flag;
        logic              zero_flag;
        logic              half_borrow_flag;
        logic              carry_flag;
        logic              signed_extra_flag;
        logic              chained_null_flag;
        logic              mem_we;
        logic [DATA_W-1:0] mem_wdata;
        logic              skip;
        logic              ready;
        logic              done;
    } sbs_regs_t;

endpackage

// [core/sbs_sub_unit.sv]
// Eight-bit subtractor producing the difference and the six status flags
module sbs_sub_unit #(
    parameter int unsigned DATA_W = sbs_pkg::DATA_W
) (
    // Operands
    input  wire logic [DATA_W-1:0] i_minuend,
    input  wire logic [DATA_W-1:0] i_subtrahend,
    // Result and flags
    output logic [DATA_W-1:0]      o_diff,
    output logic                   o_carry,
    output logic                   o_half_borrow,
    output logic                   o_arith_range,
    output logic                   o_zero,
    output logic                   o_signed_extra,
    output logic                   o_chained_null
);

    // Elaboration-time refusal: the nibble borrow and flag taps assume one byte
    if (DATA_W != sbs_pkg::DATA_W) begin
        $error("sbs_sub_unit: only an 8-bit datapath is supported");
    end

    logic [DATA_W:0]             full_diff;
    logic [sbs_pkg::NIBBLE_W:0]  low_diff;

    always_comb begin
        // Extra top bit catches the borrow; the result wraps modulo 256
        full_diff = {1'b0, i_minuend} - {1'b0, i_subtrahend};
        low_diff  = {1'b0, i_minuend[sbs_pkg::NIBBLE_W-1:0]}
                  - {1'b0, i_subtrahend[sbs_pkg::NIBBLE_W-1:0]};
        o_diff         = full_diff[DATA_W-1:0];
        // Carry means no borrow: cleared on a negative result
        o_carry        = ~full_diff[DATA_W];
        o_half_borrow  = ~low_diff[sbs_pkg::NIBBLE_W];
        o_arith_range  = (i_minuend[DATA_W-1] != i_subtrahend[DATA_W-1])
                       && (o_diff[DATA_W-1] != i_minuend[DATA_W-1]);
        o_zero         = (o_diff == sbs_pkg::ZERO_BYTE);
        o_signed_extra = o_arith_range ^ o_diff[DATA_W-1];
        o_chained_null = o_zero;
    end

endmodule

// [core/sbs_exec.sv]
// Execution unit for skip-if-nonzero, subtract and nibble exchange instructions
// Functional notes
// - bit-test skip skips next instruction when selected memory bit is one; flags untouched.
// - byte skip writes the byte back unchanged, skips when nonzero, flags untouched.
// - a taken skip adds one dummy cycle, so the instruction takes two cycles.
// - bit-test skip also takes two cycles when its skip is taken.
// - subtract memory from working register, result to working register, memory kept.
// - working register minus memory byte is written to memory; working register kept.
// - subtract instruction literal from working register, result to working register.
// - carry cleared on borrow, set when the difference is zero or positive.
// - every subtraction updates range, zero, half borrow, carry, signed extra, chained null.
// - nibble exchange swaps the memory byte halves in place; flags untouched.
// - nibble exchange to working loads swapped byte into working register; memory kept.
module sbs_exec #(
    parameter int unsigned DATA_W = sbs_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_rst_n,
    // Instruction request
    input  wire logic                       i_op_valid,
    input  wire logic [2:0]                 i_op_code,
    input  wire logic [sbs_pkg::BIT_W-1:0]  i_bit_sel,
    input  wire logic [DATA_W-1:0]          i_literal,
    input  wire logic [DATA_W-1:0]          i_mem_rdata,
    // Working register load from the rest of the core
    input  wire logic                       i_wr_load,
    input  wire logic [DATA_W-1:0]          i_wr_load_data,
    // Request handshake and sequencing
    output logic                            o_ready,
    output logic                            o_done,
    output logic                            o_skip,
    // Data memory write-back
    output logic                            o_mem_we,
    output logic [DATA_W-1:0]               o_mem_wdata,
    // Working register and status flags
    output logic [DATA_W-1:0]               o_working_register,
    output logic                            o_arith_range_flag,
    output logic                            o_zero_flag,
    output logic                            o_half_borrow_flag,
    output logic                            o_carry_flag,
    output logic                            o_signed_extra_flag,
    output logic                            o_chained_null_flag
);

    // Elaboration-time refusal of widths the swap and flag logic cannot serve
    if (DATA_W != sbs_pkg::DATA_W) begin
        $error("sbs_exec: nibble exchange and flags need an 8-bit datapath");
    end
    // The bit select must reach every bit of the byte and no more
    if ((2 ** sbs_pkg::BIT_W) != DATA_W) begin
        $error("sbs_exec: bit select width does not match the datapath");
    end

    // Swap the two halves of a byte
    function automatic logic [DATA_W-1:0] nibble_swap(input logic [DATA_W-1:0] value);
        nibble_swap = {value[sbs_pkg::NIBBLE_W-1:0], value[DATA_W-1:sbs_pkg::NIBBLE_W]};
    endfunction

    // Codes that run through the subtractor and so update all six flags
    function automatic logic is_subtract(input logic [2:0] code);
        is_subtract = (code == sbs_pkg::OP_SUB_MEM)
                   || (code == sbs_pkg::OP_MINUS_INTO_MEMORY)
                   || (code == sbs_pkg::OP_SUB_LITERAL);
    endfunction

    // Codes whose own result lands in the working register
    function automatic logic writes_working(input logic [2:0] code);
        writes_working = (code == sbs_pkg::OP_SUB_MEM)
                      || (code == sbs_pkg::OP_SUB_LITERAL)
                      || (code == sbs_pkg::OP_NIBBLE_EXCH_TO_WR);
    endfunction

    sbs_pkg::sbs_regs_t cur_r;
    sbs_pkg::sbs_regs_t cur_nxt;

    logic              accept;
    logic [DATA_W-1:0] sub_a;
    logic [DATA_W-1:0] sub_b;
    logic [DATA_W-1:0] sub_diff;
    logic              sub_carry;
    logic              sub_half;
    logic              sub_range;
    logic              sub_zero;
    logic              sub_sext;
    logic              sub_cnull;

    assign accept = i_op_valid && cur_r.ready;

    // Literal form replaces the memory operand; minuend is always the working register
    always_comb begin
        sub_a = cur_r.working_register;
        sub_b = (i_op_code == sbs_pkg::OP_SUB_LITERAL) ? i_literal : i_mem_rdata;
    end

    sbs_sub_unit #(
        .DATA_W         (DATA_W)
    ) u_sub (
        .i_minuend      (sub_a),
        .i_subtrahend   (sub_b),
        .o_diff         (sub_diff),
        .o_carry        (sub_carry),
        .o_half_borrow  (sub_half),
        .o_arith_range  (sub_range),
        .o_zero         (sub_zero),
        .o_signed_extra (sub_sext),
        .o_chained_null (sub_cnull)
    );

    always_comb begin
        logic take_flags;
        logic skip_taken;
        take_flags = 1'b0;
        skip_taken = 1'b0;
        cur_nxt           = cur_r;
        cur_nxt.mem_we    = 1'b0;
        cur_nxt.skip      = 1'b0;
        cur_nxt.done      = 1'b0;
        cur_nxt.mem_wdata = cur_r.mem_wdata;

        // Core-side load yields to an instruction writing the same register
        if (i_wr_load && !(accept && writes_working(i_op_code))) begin
            cur_nxt.working_register = i_wr_load_data;
        end

        unique case (cur_r.state)
            sbs_pkg::SBS_ST_EXEC: begin
                if (accept) begin
                    cur_nxt.done = 1'b1;
                    take_flags   = is_subtract(i_op_code);
                    case (i_op_code)
                        sbs_pkg::OP_SKIP_NONNULL_BIT: begin
                            skip_taken = i_mem_rdata[i_bit_sel];
                        end
                        sbs_pkg::OP_SKIP_NONNULL: begin
                            // Read-modify-write cycle returns the byte untouched
                            cur_nxt.mem_we    = 1'b1;
                            cur_nxt.mem_wdata = i_mem_rdata;
                            skip_taken        = (i_mem_rdata != sbs_pkg::ZERO_BYTE);
                        end
                        sbs_pkg::OP_SUB_MEM: begin
                            cur_nxt.working_register = sub_diff;
                        end
                        sbs_pkg::OP_MINUS_INTO_MEMORY: begin
                            cur_nxt.mem_we    = 1'b1;
                            cur_nxt.mem_wdata = sub_diff;
                            // Kept even against a core-side load in the same cycle
                            cur_nxt.working_register = cur_r.working_register;
                        end
                        sbs_pkg::OP_SUB_LITERAL: begin
                            cur_nxt.working_register = sub_diff;
                        end
                        sbs_pkg::OP_NIBBLE_EXCHANGE: begin
                            cur_nxt.mem_we    = 1'b1;
                            cur_nxt.mem_wdata = nibble_swap(i_mem_rdata);
                        end
                        sbs_pkg::OP_NIBBLE_EXCH_TO_WR: begin
                            cur_nxt.working_register = nibble_swap(i_mem_rdata);
                        end
                        default: begin
                            // Unknown code: completes with no effect
                            cur_nxt.done = 1'b1;
                        end
                    endcase
                    if (take_flags) begin
                        cur_nxt.arith_range_flag  = sub_range;
                        cur_nxt.zero_flag         = sub_zero;
                        cur_nxt.half_borrow_flag  = sub_half;
                        cur_nxt.carry_flag        = sub_carry;
                        cur_nxt.signed_extra_flag = sub_sext;
                        cur_nxt.chained_null_flag = sub_cnull;
                    end
                    if (skip_taken) begin
                        // Hold off the next request for the dummy fetch cycle
                        cur_nxt.skip  = 1'b1;
                        cur_nxt.ready = 1'b0;
                        cur_nxt.state = sbs_pkg::SBS_ST_DUMMY;
                    end
                end
            end
            sbs_pkg::SBS_ST_DUMMY: begin
                // A request in this cycle is not accepted, since o_ready is low
                cur_nxt.ready = 1'b1;
                cur_nxt.state = sbs_pkg::SBS_ST_EXEC;
            end
        endcase
    end

    // Whole state registered in one place, so every output is a flip-flop
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur_r.state             <= sbs_pkg::SBS_ST_EXEC;
            cur_r.working_register  <= sbs_pkg::WR_RESET;
            cur_r.arith_range_flag  <= sbs_pkg::FLAG_RST;
            cur_r.zero_flag         <= sbs_pkg::FLAG_RST;
            cur_r.half_borrow_flag  <= sbs_pkg::FLAG_RST;
            cur_r.carry_flag        <= sbs_pkg::FLAG_RST;
            cur_r.signed_extra_flag <= sbs_pkg::FLAG_RST;
            cur_r.chained_null_flag <= sbs_pkg::FLAG_RST;
            cur_r.mem_we            <= 1'b0;
            cur_r.mem_wdata         <= sbs_pkg::ZERO_BYTE;
            cur_r.skip              <= 1'b0;
            cur_r.ready             <= 1'b1;
            cur_r.done              <= 1'b0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign o_ready             = cur_r.ready;
    assign o_done              = cur_r.done;
    assign o_skip              = cur_r.skip;
    assign o_mem_we            = cur_r.mem_we;
    assign o_mem_wdata         = cur_r.mem_wdata;
    assign o_working_register  = cur_r.working_register;
    assign o_arith_range_flag  = cur_r.arith_range_flag;
    assign o_zero_flag         = cur_r.zero_flag;
    assign o_half_borrow_flag  = cur_r.half_borrow_flag;
    assign o_carry_flag        = cur_r.carry_flag;
    assign o_signed_extra_flag = cur_r.signed_extra_flag;
    assign o_chained_null_flag = cur_r.chained_null_flag;

endmodule

// [tb/sbs_exec_sva.sv]
// Assertions for the subtract, swap and skip execution unit
module sbs_exec_sva #(
    parameter int unsigned DATA_W = 8
) (
    input wire logic              i_sys_clk,
    input wire logic              i_rst_n,
    input wire logic              i_op_valid,
    input wire logic [2:0]        i_op_code,
    input wire logic [2:0]        i_bit_sel,
    input wire logic [DATA_W-1:0] i_literal,
    input wire logic [DATA_W-1:0] i_mem_rdata,
    input wire logic              i_wr_load,
    input wire logic              o_ready,
    input wire logic              o_done,
    input wire logic              o_skip,
    input wire logic              o_mem_we,
    input wire logic [DATA_W-1:0] o_mem_wdata,
    input wire logic [DATA_W-1:0] o_working_register,
    input wire logic              o_arith_range_flag,
    input wire logic              o_zero_flag,
    input wire logic              o_half_borrow_flag,
    input wire logic              o_carry_flag,
    input wire logic              o_signed_extra_flag,
    input wire logic              o_chained_null_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic              acc;
    logic              sub;
    logic              bit_r;
    logic [DATA_W-1:0] mem_r;
    logic [DATA_W-1:0] opnd_r;
    logic [5:0]        flg;
    assign acc = i_op_valid && o_ready;
    assign sub = acc && (i_op_code inside {3'h2, 3'h3, 3'h4});
    assign flg = {o_arith_range_flag, o_zero_flag, o_half_borrow_flag,
                  o_carry_flag, o_signed_extra_flag, o_chained_null_flag};
    // Operands captured at the accepting edge
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {bit_r, mem_r, opnd_r} <= '0;
        end else begin
            bit_r  <= i_mem_rdata[i_bit_sel];
            mem_r  <= i_mem_rdata;
            opnd_r <= (i_op_code == 3'h4) ? i_literal : i_mem_rdata;
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    skip_dummy_a: assert property (o_skip |-> !o_ready ##1 (o_ready && !o_done))
        else $error("skip without one dummy cycle");
    done_pulse_a: assert property (acc |=> o_done)
        else $error("accepted request gave no done");
    bit_skip_a: assert property (acc && i_op_code == 3'h0 |=> o_skip == bit_r && !o_mem_we)
        else $error("bit skip decision wrong");
    byte_skip_a: assert property (acc && i_op_code == 3'h1 |=>
        o_skip == (mem_r != '0) && o_mem_we && o_mem_wdata == mem_r) else $error("byte skip wrong");
    flag_hold_a: assert property (acc && !sub |=> $stable(flg))
        else $error("flags moved on non subtract");
    swap_mem_a: assert property (acc && i_op_code == 3'h5 |=>
        o_mem_we && o_mem_wdata == {mem_r[3:0], mem_r[7:4]}) else $error("nibble swap wrong");
    swap_wr_a: assert property (acc && i_op_code == 3'h6 |=>
        !o_mem_we && o_working_register == {mem_r[3:0], mem_r[7:4]}) else $error("swap to wr wrong");
    sub_wr_a: assert property (acc && i_op_code inside {3'h2, 3'h4} |=>
        !o_mem_we && o_working_register == $past(o_working_register) - opnd_r) else $error("sub wrong");
    sub_mem_a: assert property (acc && i_op_code == 3'h3 && !i_wr_load |=> o_mem_we &&
        o_mem_wdata == $past(o_working_register) - mem_r && $stable(o_working_register)) else $error("sub mem");
    carry_a: assert property (sub |=> o_carry_flag == ($past(o_working_register) >= opnd_r))
        else $error("carry flag wrong");
    zero_a: assert property (sub |=> o_zero_flag == ($past(o_working_register) == opnd_r)
        && o_chained_null_flag == o_zero_flag) else $error("zero flags wrong");
    cover property (o_skip);
    cover property (acc && i_op_code == 3'h3);
    cover property (sub ##1 !o_carry_flag);
    cover property (acc && i_wr_load);
endmodule
bind sbs_exec sbs_exec_sva #(.DATA_W(DATA_W)) i_sbs_exec_sva (.*);

// [tb/subtract_swap_skip_ops_tb.sv]
// Self-checking bench for the subtract, swap and skip execution unit
module subtract_swap_skip_ops_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic       skip;
        logic       we;
        logic [7:0] wdata;
        logic [7:0] wr;
        logic [5:0] flg;
    } sbs_note_t;
    logic       clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, wr_load = 1'b0;
    logic [2:0] op_code = 3'h0, bit_sel = 3'h0;
    logic [7:0] literal = 8'h00, mem_rdata = 8'h00, wr_load_data = 8'h00;
    logic       ready, done, skip, mem_we;
    logic [7:0] mem_wdata, wr, wr_m = 8'h00;
    wire  [5:0] flg;
    logic [5:0] flg_m = 6'h00;
    sbs_note_t  notes[$];
    int         miscompares = 0, check_count = 0, cycles = 0, seed;
    sbs_exec i_sbs_exec (.i_sys_clk(clk), .i_rst_n(rst_n), .i_op_valid(op_valid), .i_op_code(op_code),
        .i_bit_sel(bit_sel), .i_literal(literal), .i_mem_rdata(mem_rdata), .i_wr_load(wr_load),
        .i_wr_load_data(wr_load_data), .o_ready(ready), .o_done(done), .o_skip(skip), .o_mem_we(mem_we),
        .o_mem_wdata(mem_wdata), .o_working_register(wr), .o_arith_range_flag(flg[5]), .o_zero_flag(flg[4]),
        .o_half_borrow_flag(flg[3]), .o_carry_flag(flg[2]), .o_signed_extra_flag(flg[1]),
        .o_chained_null_flag(flg[0]));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Called just after a rising edge; the next edge accepts
    task automatic issue(input logic [2:0] code, input logic ld);
        logic [7:0] m, l, b, d, q;
        logic [2:0] s;
        logic       ov;
        sbs_note_t  n;
        m = ($urandom % 4 == 0) ? 8'h00 : 8'($urandom);
        l = ($urandom % 4 == 0) ? wr_m : 8'($urandom);
        s = 3'($urandom);
        q = 8'($urandom);
        b = (code == sbs_pkg::OP_SUB_LITERAL) ? l : m;
        d = wr_m - b;
        ov = (wr_m[7] != b[7]) && (d[7] != wr_m[7]);
        n = {1'b0, 1'b0, 8'h00, wr_m, flg_m};
        case (code)
            sbs_pkg::OP_SKIP_NONNULL_BIT: n.skip = m[s];
            sbs_pkg::OP_SKIP_NONNULL: n = {|m, 1'b1, m, wr_m, flg_m};
            sbs_pkg::OP_SUB_MEM, sbs_pkg::OP_SUB_LITERAL: n.wr = d;
            sbs_pkg::OP_MINUS_INTO_MEMORY: n = {1'b0, 1'b1, d, wr_m, flg_m};
            sbs_pkg::OP_NIBBLE_EXCHANGE: n = {1'b0, 1'b1, m[3:0], m[7:4], wr_m, flg_m};
            sbs_pkg::OP_NIBBLE_EXCH_TO_WR: n.wr = {m[3:0], m[7:4]};
            default: n.wr = wr_m;
        endcase
        if (code inside {3'h2, 3'h3, 3'h4}) begin
            n.flg = {ov, d == 8'h00, wr_m[3:0] >= b[3:0], wr_m >= b, ov ^ d[7], d == 8'h00};
        end
        // A load in the same cycle lands only where the instruction neither writes the register nor subtracts into memory
        if (ld && !(code inside {3'h2, 3'h3, 3'h4, 3'h6})) n.wr = q;
        {wr_m, flg_m} = {n.wr, n.flg};
        notes.push_back(n);
        {op_valid, wr_load, wr_load_data} <= {1'b1, ld, q};
        {op_code, bit_sel, literal, mem_rdata} <= {code, s, l, m};
        @(posedge clk);
        if (n.skip) begin
            // Dummy cycle: keep the request and load lines quiet
            {op_valid, wr_load} <= 2'b00;
            @(posedge clk);
        end
    endtask
    // The following issue call releases the load line unless its own ld argument raises it again
    task automatic load_wr();
        wr_m = 8'($urandom);
        {op_valid, wr_load, wr_load_data} <= {1'b0, 1'b1, wr_m};
        @(posedge clk);
    endtask
    always @(posedge clk) begin
        sbs_note_t n;
        if (done === 1'b1) begin
            if (notes.size() == 0) begin
                check(8'h01, 8'h00, "done without request");
            end else begin
                n = notes.pop_front();
                check(8'(skip), 8'(n.skip), "skip");
                check(8'(mem_we), 8'(n.we), "write strobe");
                if (n.we) check(mem_wdata, n.wdata, "write data");
                check(wr, n.wr, "working register");
                check(8'(flg), 8'(n.flg), "flags");
            end
        end
        cycles++;
        if (cycles == 6000) begin
            check(8'h01, 8'h00, "timeout");
            tally_and_finish();
        end
    end
    initial begin
        seed = $urandom(47158);
        repeat (3) @(posedge clk);
        @(negedge clk);
        check({ready, done, skip, mem_we, 4'h0}, 8'h80, "reset strobes");
        check(wr, 8'h00, "reset working register");
        check(mem_wdata, 8'h00, "reset write data");
        check(8'(flg), 8'h00, "reset flags");
        @(posedge clk);
        rst_n <= 1'b1;
        $display("test reset values done");
        for (int i = 0; i < 24; i++) begin
            issue(3'(i), i >= 16);
        end
        $display("test code sweep done");
        for (int i = 0; i < 500; i++) begin
            if ($urandom % 5 == 0) load_wr();
            issue(3'($urandom), $urandom % 4 == 0);
        end
        {op_valid, wr_load} <= 2'b00;
        repeat (3) @(posedge clk);
        check(8'(notes.size()), 8'h00, "pending results");
        $display("test random mix done");
        tally_and_finish();
    end
endmodule
